//--- hw/spims_pkg.sv
// Behaviour
// - Slave sets status bit 7 once the first byte after select is received.
// - Overflow flag at bit 6 sets on FIFO overflow; any write clears it.
// - Output direction: empty transmit FIFO overflows; input direction: full receive FIFO.
// - First-byte flag at bit 5 sets on first slave byte; any write clears it.
// - Byte-done flag bit 4 sets per byte; cleared by write or auto-clear access.
// - Idle flag at bit 3 resets to 1 and reads 1 while no shifting.
// - Status bit 2 shows transmit FIFO count, zero or one.
// - Status bit 0 shows receive FIFO count; bit 1 reads zero.
// - Master supports clock modes 0 and 3, chosen by the clock-format bit.
// - Incoming serial data is sampled on the rising serial clock edge.
// - Master drives SCK; chip select comes from a software-driven pin.
// - Data register write loads transmit FIFO and starts one 8-bit transfer.
// - Data read starts a transfer only when direction is input.
// - Slave takes SCK as input from the host; drivers set by software.
// - Slave MISO is driven automatically only while chip select is low.
// - On select the slave loads the preset byte into its shift buffer.
// - Preset byte bit 7 (bit 0 when setup bit 3 selects LSB first) stands on MISO while SCK is low after select.
// - Output direction: only writes are effective; input: reads and writes both.
// - Mode 0 serial clock idles low; mode 3 idles high.
// - Clear-all bit empties both FIFOs and flags; it resets to one.
package spims_pkg;
    localparam logic [5:0] IDX_SETUP = 6'h00;
    localparam logic [5:0] IDX_CKDIV = 6'h01;
    localparam logic [5:0] IDX_PRE = 6'h02;
    localparam logic [5:0] IDX_CTRL = 6'h03;
    localparam logic [5:0] IDX_DATA = 6'h04;
    localparam logic [5:0] IDX_STAT = 6'h05;

    localparam logic [7:0] RST_SETUP = 8'h00;
    localparam logic [7:0] RST_CKDIV = 8'h20;
    localparam logic [7:0] RST_PRE = 8'h20;
    localparam logic [7:0] RST_CTRL = 8'h02;

    localparam int SETUP_SLAVE = 7;
    localparam int SETUP_LSB = 3;
    localparam int CTRL_MISO_OE = 7;
    localparam int CTRL_MOSI_OE = 6;
    localparam int CTRL_SCK_OE = 5;
    localparam int CTRL_DIR = 4;
    localparam int CTRL_MST_CLK = 3;
    localparam int CTRL_CLR_ALL = 1;
    localparam int CTRL_AUTO = 0;

    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] LAST_RISE = 4'h8;
    localparam logic [6:0] HALF_MIN = 7'h01;
    localparam int SYNC_W = 4;

    typedef enum logic [0:0] {
        MST_IDLE = 1'b0,
        MST_SHIFT = 1'b1
    } spims_mst_t;

    function automatic logic [7:0] spims_ord(input logic [7:0] b, input logic lsb);
        logic [7:0] r;
        r = b;
        if (lsb) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = b[7 - i];
            end
        end
        return r;
    endfunction
endpackage

//--- hw/spims_sync.sv
`timescale 1ns/1ps
module spims_sync (
    input wire logic ref_clk,                          // System clock
    input wire logic rst,                              // Async reset, active high
    input wire logic [spims_pkg::SYNC_W-1:0] d,        // Pin levels
    output logic [spims_pkg::SYNC_W-1:0] q             // Synchronised levels
);
    typedef struct packed {
        logic [spims_pkg::SYNC_W-1:0] s1;
        logic [spims_pkg::SYNC_W-1:0] s2;
    } spims_sync_t;

    spims_sync_t r;
    spims_sync_t next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule

//--- hw/spims_div.sv
`timescale 1ns/1ps
module spims_div (
    input wire logic ref_clk,      // System clock
    input wire logic rst,          // Async reset, active high
    input wire logic run,          // Count while high
    input wire logic [6:0] half,   // Cycles per half period
    output logic tick              // One-cycle pulse per half period
);
    typedef struct packed {
        logic [6:0] cnt;
        logic tick;
    } spims_div_t;

    spims_div_t r;
    spims_div_t next_r;

    always_comb begin
        next_r = r;
        if (!run) begin
            next_r.cnt = 7'h00;
            next_r.tick = 1'b0;
        end else if (r.cnt >= half - spims_pkg::HALF_MIN) begin
            next_r.cnt = 7'h00;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 7'h01;
            next_r.tick = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;
endmodule

//--- hw/spims_top.sv
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module spims_top (
    input wire logic ref_clk,          // System clock, 50 MHz
    input wire logic rst,              // Async reset, active high
    input wire logic hsel,             // AHB select
    input wire logic [31:0] haddr,     // AHB address
    input wire logic [1:0] htrans,     // AHB transfer type
    input wire logic hwrite,           // AHB write
    input wire logic [2:0] hsize,      // AHB size, word only
    input wire logic [31:0] hwdata,    // AHB write data
    input wire logic hready,           // AHB bus ready
    output logic [31:0] hrdata,        // AHB read data
    output logic hreadyout,            // AHB slave ready
    output logic hresp,                // AHB response, always OKAY
    input wire logic sck_in,           // SCK pin level
    output logic sck_out,              // SCK pin drive value
    output logic sck_oe,               // SCK pin drive enable
    input wire logic mosi_in,          // MOSI pin level
    output logic mosi_out,             // MOSI pin drive value
    output logic mosi_oe,              // MOSI pin drive enable
    input wire logic miso_in,          // MISO pin level
    output logic miso_out,             // MISO pin drive value
    output logic miso_oe,              // MISO pin drive enable
    input wire logic cs_n_in,          // Slave chip select, low active
    output logic irq                   // Interrupt request, high active
);
    typedef struct packed {
        logic [7:0] setup;
        logic [7:0] ckdiv;
        logic [7:0] pre;
        logic [7:0] ctrl;
        logic [7:0] tx_data;
        logic [7:0] rx_data;
        logic [7:0] sh;
        logic tx_full;
        logic rx_full;
        logic flag_ov;
        logic flag_first;
        logic flag_byte;
        logic fst_act;
        spims_pkg::spims_mst_t mst;
        logic [3:0] rises;
        logic rx_bit;
        logic start_req;
        logic sck_lvl;
        logic [3:0] bitcnt;
        logic first_pend;
        logic cs_prev;
        logic sck_prev;
        logic wr_pend;
        logic [5:0] wr_idx;
        logic [31:0] hrdata;
        logic hreadyout;
        logic irq;
        logic sck_out;
        logic sck_oe;
        logic mosi_out;
        logic mosi_oe;
        logic miso_out;
        logic miso_oe;
    } spims_state_t;

    spims_state_t r;
    spims_state_t next_r;
    logic [spims_pkg::SYNC_W-1:0] pins;
    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic cs_s;
    logic tick;
    logic [6:0] half;
    logic slave;
    logic dir;
    logic mode3;
    logic lsb;
    logic idle;
    logic addr_ph;
    logic [7:0] rd_byte;
    logic eff;
    logic m_done;
    logic s_done;

    spims_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .d({sck_in, mosi_in, miso_in, cs_n_in}),
        .q(pins)
    );

    assign sck_s = pins[3];
    assign mosi_s = pins[2];
    assign miso_s = pins[1];
    assign cs_s = pins[0];

    // Half period in system cycles, at least one
    assign half = (r.ckdiv[7:1] == 7'h00) ? spims_pkg::HALF_MIN : r.ckdiv[7:1];

    spims_div u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(r.mst == spims_pkg::MST_SHIFT),
        .half(half),
        .tick(tick)
    );

    assign slave = r.setup[spims_pkg::SETUP_SLAVE];
    assign dir = r.ctrl[spims_pkg::CTRL_DIR];
    assign mode3 = r.ctrl[spims_pkg::CTRL_MST_CLK];
    assign lsb = r.setup[spims_pkg::SETUP_LSB];
    assign idle = (r.mst == spims_pkg::MST_IDLE) && !r.start_req && (r.bitcnt == 4'h0);
    assign addr_ph = hsel && htrans[1] && hready;

    always_comb begin
        unique case (haddr[7:2])
            spims_pkg::IDX_SETUP: rd_byte = {r.setup[7:3], 1'b0, slave && !cs_s, r.first_pend && r.bitcnt == 4'h0};
            spims_pkg::IDX_CKDIV: rd_byte = r.ckdiv;
            spims_pkg::IDX_PRE: rd_byte = r.pre;
            spims_pkg::IDX_CTRL: rd_byte = r.ctrl;
            spims_pkg::IDX_DATA: rd_byte = r.rx_data;
            spims_pkg::IDX_STAT: rd_byte = {r.fst_act, r.flag_ov, r.flag_first, r.flag_byte,
                                            idle, r.tx_full, 1'b0, r.rx_full};
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_r = r;
        eff = 1'b0;
        m_done = 1'b0;
        s_done = 1'b0;
        // Data phase of a write, software clears come before hardware sets
        next_r.wr_pend = 1'b0;
        if (r.wr_pend) begin
            case (r.wr_idx)
                spims_pkg::IDX_SETUP: next_r.setup[7:3] = hwdata[7:3];
                spims_pkg::IDX_CKDIV: next_r.ckdiv = hwdata[7:0];
                spims_pkg::IDX_PRE: next_r.pre = hwdata[7:0];
                spims_pkg::IDX_CTRL: next_r.ctrl = hwdata[7:0];
                spims_pkg::IDX_DATA: begin
                    next_r.tx_data = hwdata[7:0];
                    next_r.tx_full = 1'b1;
                    eff = 1'b1;
                end
                spims_pkg::IDX_STAT: begin
                    next_r.flag_ov = 1'b0;
                    next_r.flag_first = 1'b0;
                    next_r.flag_byte = 1'b0;
                end
                default: next_r.wr_pend = 1'b0;
            endcase
        end
        if (addr_ph) begin
            if (hwrite) begin
                next_r.wr_pend = 1'b1;
                next_r.wr_idx = haddr[7:2];
            end else begin
                next_r.hrdata = {24'h000000, rd_byte};
                if (haddr[7:2] == spims_pkg::IDX_DATA) begin
                    next_r.rx_full = 1'b0;
                    eff = eff | dir;
                end
            end
        end
        if (eff) begin
            if (r.ctrl[spims_pkg::CTRL_AUTO]) begin
                next_r.flag_byte = 1'b0;
            end
            if (!slave) begin
                next_r.start_req = 1'b1;
            end
        end
        // Master engine
        unique case (r.mst)
            spims_pkg::MST_IDLE: begin
                next_r.sck_lvl = mode3;
                if (r.start_req && !slave) begin
                    next_r.start_req = 1'b0;
                    next_r.sh = spims_pkg::spims_ord(r.tx_data, lsb);
                    next_r.tx_full = 1'b0;
                    next_r.rises = 4'h0;
                    next_r.mst = spims_pkg::MST_SHIFT;
                end
            end
            spims_pkg::MST_SHIFT: begin
                if (tick) begin
                    next_r.sck_lvl = !r.sck_lvl;
                    if (!r.sck_lvl) begin
                        next_r.rises = r.rises + 4'h1;
                        next_r.rx_bit = miso_s;
                        if (mode3 && r.rises == spims_pkg::LAST_BIT) begin
                            next_r.sh = {r.sh[6:0], miso_s};
                            m_done = 1'b1;
                        end
                    end else begin
                        if (r.rises != 4'h0) begin
                            next_r.sh = {r.sh[6:0], r.rx_bit};
                        end
                        if (!mode3 && r.rises == spims_pkg::LAST_RISE) begin
                            m_done = 1'b1;
                        end
                    end
                end
            end
        endcase
        if (m_done) begin
            next_r.rx_data = spims_pkg::spims_ord(next_r.sh, lsb);
            next_r.rx_full = 1'b1;
            next_r.flag_byte = 1'b1;
            next_r.mst = spims_pkg::MST_IDLE;
        end
        // Slave engine, on the system clock, stepped by rising edges of the synchronised SCK
        next_r.cs_prev = cs_s;
        next_r.sck_prev = sck_s;
        if (slave) begin
            if (r.cs_prev && !cs_s) begin
                next_r.sh = spims_pkg::spims_ord(r.pre, lsb);
                next_r.bitcnt = 4'h0;
                next_r.first_pend = 1'b1;
                next_r.fst_act = 1'b0;
            end else if (cs_s) begin
                next_r.bitcnt = 4'h0;
            end else if (!r.sck_prev && sck_s) begin
                next_r.sh = {r.sh[6:0], mosi_s};
                next_r.bitcnt = r.bitcnt + 4'h1;
                if (r.bitcnt == spims_pkg::LAST_BIT) begin
                    s_done = 1'b1;
                    next_r.bitcnt = 4'h0;
                    next_r.rx_data = spims_pkg::spims_ord(next_r.sh, lsb);
                    if (next_r.rx_full && dir) begin
                        next_r.flag_ov = 1'b1;
                    end
                    next_r.rx_full = 1'b1;
                    next_r.flag_byte = 1'b1;
                    if (r.first_pend) begin
                        next_r.flag_first = 1'b1;
                        next_r.fst_act = 1'b1;
                        next_r.first_pend = 1'b0;
                    end
                    if (next_r.tx_full) begin
                        next_r.sh = spims_pkg::spims_ord(next_r.tx_data, lsb);
                        next_r.tx_full = 1'b0;
                    end else if (!dir) begin
                        next_r.flag_ov = 1'b1;
                    end
                end
            end else if (r.bitcnt == 4'h0 && !r.first_pend && next_r.tx_full) begin
                next_r.sh = spims_pkg::spims_ord(next_r.tx_data, lsb);
                next_r.tx_full = 1'b0;
            end
        end
        if (r.ctrl[spims_pkg::CTRL_CLR_ALL]) begin
            next_r.tx_full = 1'b0;
            next_r.rx_full = 1'b0;
            next_r.flag_ov = 1'b0;
            next_r.flag_first = 1'b0;
            next_r.flag_byte = 1'b0;
            next_r.fst_act = 1'b0;
        end
        next_r.sck_out = next_r.sck_lvl;
        next_r.mosi_out = next_r.sh[7];
        next_r.miso_out = next_r.sh[7];
        next_r.sck_oe = r.ctrl[spims_pkg::CTRL_SCK_OE];
        next_r.mosi_oe = r.ctrl[spims_pkg::CTRL_MOSI_OE];
        next_r.miso_oe = slave ? !cs_s : r.ctrl[spims_pkg::CTRL_MISO_OE];
        next_r.irq = |({next_r.flag_ov, next_r.flag_first, next_r.flag_byte} & next_r.setup[6:4]);
        next_r.hreadyout = 1'b1;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.setup <= spims_pkg::RST_SETUP;
            r.ckdiv <= spims_pkg::RST_CKDIV;
            r.pre <= spims_pkg::RST_PRE;
            r.ctrl <= spims_pkg::RST_CTRL;
            r.cs_prev <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign hrdata = r.hrdata;
    assign hreadyout = r.hreadyout;
    assign hresp = 1'b0;
    assign sck_out = r.sck_out;
    assign sck_oe = r.sck_oe;
    assign mosi_out = r.mosi_out;
    assign mosi_oe = r.mosi_oe;
    assign miso_out = r.miso_out;
    assign miso_oe = r.miso_oe;
    assign irq = r.irq;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_reserved_zero: assert property (
        (addr_ph && !hwrite && haddr[7:2] == spims_pkg::IDX_STAT) |=> (hrdata[1] == 1'b0 && hrdata[31:8] == 24'h000000)
    ) else $error("reserved status bits not zero");
    a_sck_idle_level: assert property (
        (r.mst == spims_pkg::MST_IDLE && !r.start_req) |=> (sck_out == $past(mode3))
    ) else $error("serial clock idle level wrong");
    a_write_starts: assert property (
        (r.wr_pend && r.wr_idx == spims_pkg::IDX_DATA && !slave && !r.ctrl[spims_pkg::CTRL_CLR_ALL]
         && r.mst == spims_pkg::MST_IDLE && !r.start_req) |=> ##1 (r.mst == spims_pkg::MST_SHIFT)
    ) else $error("data write did not start a transfer");
    a_read_no_start: assert property (
        (addr_ph && !hwrite && haddr[7:2] == spims_pkg::IDX_DATA && !dir && !r.wr_pend && !slave
         && r.mst == spims_pkg::MST_IDLE && !r.start_req) |=> !r.start_req
    ) else $error("read started a transfer in output direction");
    a_irq_gating: assert property (
        irq == |({r.flag_ov, r.flag_first, r.flag_byte} & r.setup[6:4])
    ) else $error("interrupt request mismatch");
    a_clear_all: assert property (
        r.ctrl[spims_pkg::CTRL_CLR_ALL] |=> (!r.tx_full && !r.rx_full && !r.flag_byte && !r.flag_ov && !r.flag_first)
    ) else $error("clear-all left state behind");
    a_miso_auto_oe: assert property (
        (slave && !cs_s) |=> miso_oe
    ) else $error("slave miso not driven while selected");
    a_byte_done: assert property (
        (m_done && !r.ctrl[spims_pkg::CTRL_CLR_ALL]) |=> (r.flag_byte && r.rx_full && r.mst == spims_pkg::MST_IDLE)
    ) else $error("byte completion not reported");
    a_preload_load: assert property (
        (slave && r.cs_prev && !cs_s) |=> (r.sh == spims_pkg::spims_ord($past(r.pre), $past(lsb)))
    ) else $error("preset byte not loaded on select");
    a_first_flag: assert property (
        (s_done && r.first_pend && !r.ctrl[spims_pkg::CTRL_CLR_ALL]) |=> (r.flag_first && r.fst_act)
    ) else $error("first byte flags not set");
    a_tx_overflow: assert property (
        (s_done && !dir && !r.tx_full && !r.wr_pend && !r.ctrl[spims_pkg::CTRL_CLR_ALL]) |=> r.flag_ov
    ) else $error("overflow not flagged on empty transmit fifo");

    c_master_done: cover property (m_done);
    c_slave_done: cover property (s_done);
    c_overflow: cover property (!r.flag_ov ##1 r.flag_ov);
    c_first: cover property (!r.flag_first ##1 r.flag_first);
endmodule

//--- sim/spims_peer.sv
`timescale 1ns/1ps
module spims_peer (
    input wire logic sck_w,    // SCK wire level
    input wire logic mosi_w,   // MOSI wire level
    input wire logic miso_w,   // MISO wire level
    output logic p_sck,        // SCK from the host role
    output logic p_mosi,       // MOSI from the host role
    output logic p_miso,       // MISO from the slave role
    output logic p_cs_n        // Chip select from the host role
);
    logic is_host = 1'b0;
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    int nrise = 0;

    initial begin
        p_sck = 1'b0;
        p_mosi = 1'b0;
        p_cs_n = 1'b1;
    end

    // Slave role takes MOSI on every rise
    always @(posedge sck_w) begin
        if (!is_host) begin
            rx <= {rx[6:0], mosi_w};
            nrise <= nrise + 1;
        end
    end

    // Next bit only on a fall after a rise, so mode 3 keeps bit 7 over its first fall
    always @(negedge sck_w) begin
        if (!is_host && nrise > 0) begin
            tx <= {tx[6:0], ~tx[7]};
        end
    end

    // As host the MISO line is not ours: once released it must not keep the last bit
    assign p_miso = is_host ? ~rx[0] : tx[7];

    task automatic host_cs(input logic v);
        p_cs_n = v;
        #400;
    endtask

    // Mode 0 host at a 160 ns link period; MOSI changes while SCK is low
    task automatic host_xfer(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            p_mosi = d[i];
            #80;
            p_sck = 1'b1;
            rx = {rx[6:0], miso_w};
            #80;
            p_sck = 1'b0;
        end
        #400;
    endtask
endmodule

//--- sim/test_spi_master_slave_controller.sv
`timescale 1ns/1ps
module test_spi_master_slave_controller;
    logic ref_clk, rst, hsel, hwrite, hready;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq;
    logic p_sck, p_mosi, p_miso, p_cs_n;
    wire sck_w = sck_oe ? sck_out : p_sck;
    wire mosi_w = mosi_oe ? mosi_out : p_mosi;
    wire miso_w = miso_oe ? miso_out : p_miso;
    int n_mismatch = 0;
    int cmp_count = 0;

    assign hready = hreadyout;

    spims_top i_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .cs_n_in(p_cs_n), .irq(irq));
    spims_peer i_peer (.sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w), .p_sck(p_sck), .p_mosi(p_mosi),
        .p_miso(p_miso), .p_cs_n(p_cs_n));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic ahb_go(input logic [5:0] idx, input logic wr, input logic [7:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
    endtask

    task automatic ahb_rd(input logic [5:0] idx, output logic [7:0] d);
        ahb_go(idx, 1'b0, 8'h00);
        d = hrdata[7:0];
    endtask

    task automatic wait_idle(output logic [7:0] s0);
        logic [7:0] v;
        int n;
        n = 0;
        ahb_rd(spims_pkg::IDX_STAT, v);
        s0 = v;
        chk("busy", 8'h00, v & 8'h08);
        while (v[3] !== 1'b1 && n < 400) begin
            ahb_rd(spims_pkg::IDX_STAT, v);
            n++;
        end
        chk("idle", 8'h08, v & 8'h08);
    endtask

    task automatic t_reset();
        logic [7:0] v;
        logic [5:0] ix [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h3F};
        logic [7:0] ex [6] = '{8'h00, 8'h20, 8'h20, 8'h02, 8'h08, 8'h00};
        for (int i = 0; i < 6; i++) begin
            ahb_rd(ix[i], v);
            chk("reset value", ex[i], v);
        end
        chk("hresp", 8'h00, {7'h0, hresp});
        ahb_go(spims_pkg::IDX_CKDIV, 1'b1, 8'h08);
        ahb_go(spims_pkg::IDX_STAT, 1'b1, 8'hFF);
        ahb_rd(spims_pkg::IDX_STAT, v);
        chk("status ro", 8'h08, v);
        $display("reset test done");
    endtask

    task automatic t_master(input logic m3);
        logic [7:0] v;
        ahb_go(spims_pkg::IDX_SETUP, 1'b1, 8'h10);
        ahb_go(spims_pkg::IDX_CTRL, 1'b1, {4'h6, m3, 3'h0});
        repeat (4) @(posedge ref_clk);
        chk("sck idle", {7'h0, m3}, {7'h0, sck_out});
        chk("drive en", 8'h03, {6'h0, sck_oe, mosi_oe});
        i_peer.tx = 8'hC3;
        i_peer.nrise = 0;
        ahb_go(spims_pkg::IDX_DATA, 1'b1, 8'hA5);
        wait_idle(v);
        chk("peer rx", 8'hA5, i_peer.rx);
        chk("rises", 8'h08, 8'(i_peer.nrise));
        ahb_rd(spims_pkg::IDX_STAT, v);
        chk("done status", 8'h19, v);
        chk("irq", 8'h01, {7'h0, irq});
        ahb_rd(spims_pkg::IDX_DATA, v);
        chk("master rx", 8'hC3, v);
        ahb_go(spims_pkg::IDX_STAT, 1'b1, 8'h00);
        ahb_rd(spims_pkg::IDX_STAT, v);
        chk("cleared", 8'h08, v);
        chk("irq off", 8'h00, {7'h0, irq});
        chk("sck idle", {7'h0, m3}, {7'h0, sck_out});
        $display("master test done");
    endtask

    task automatic t_dir_in();
        logic [7:0] v;
        ahb_go(spims_pkg::IDX_CTRL, 1'b1, 8'h71);
        ahb_go(spims_pkg::IDX_DATA, 1'b1, 8'h0F);
        wait_idle(v);
        i_peer.rx = 8'h00;
        ahb_rd(spims_pkg::IDX_DATA, v);
        wait_idle(v);
        chk("auto clear", 8'h00, v & 8'h10);
        chk("resend", 8'h0F, i_peer.rx);
        ahb_go(spims_pkg::IDX_CTRL, 1'b1, 8'h73);
        ahb_rd(spims_pkg::IDX_STAT, v);
        chk("clear all", 8'h08, v);
        chk("irq off", 8'h00, {7'h0, irq});
        $display("direction test done");
    endtask

    task automatic t_slave();
        logic [7:0] v;
        ahb_go(spims_pkg::IDX_CTRL, 1'b1, 8'h80);
        ahb_go(spims_pkg::IDX_SETUP, 1'b1, 8'h80);
        ahb_go(spims_pkg::IDX_PRE, 1'b1, 8'h96);
        repeat (2) @(posedge ref_clk);
        chk("unselected", 8'h00, {5'h0, sck_oe, mosi_oe, miso_oe});
        i_peer.is_host = 1'b1;
        i_peer.host_cs(1'b0);
        chk("selected", 8'h03, {6'h0, miso_oe, miso_out});
        i_peer.host_xfer(8'h3C);
        chk("host rx", 8'h96, i_peer.rx);
        ahb_rd(spims_pkg::IDX_STAT, v);
        chk("first byte", 8'hB1, v & 8'hB5);
        chk("overflow first", 8'h40, v & 8'h40);
        ahb_rd(spims_pkg::IDX_DATA, v);
        chk("slave rx", 8'h3C, v);
        ahb_go(spims_pkg::IDX_STAT, 1'b1, 8'h00);
        i_peer.host_xfer(8'h00);
        ahb_rd(spims_pkg::IDX_STAT, v);
        chk("overflow", 8'h40, v & 8'h40);
        ahb_go(spims_pkg::IDX_STAT, 1'b1, 8'h00);
        ahb_rd(spims_pkg::IDX_STAT, v);
        chk("flags clear", 8'h00, v & 8'h70);
        ahb_go(spims_pkg::IDX_DATA, 1'b1, 8'h5A);
        i_peer.host_xfer(8'hFF);
        chk("host rx2", 8'h5A, i_peer.rx);
        i_peer.host_cs(1'b1);
        chk("released", 8'h00, {7'h0, miso_oe});
        $display("slave test done");
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_master(1'b0);
        t_master(1'b1);
        t_dir_in();
        t_slave();
        report_and_stop();
    end
endmodule
